// ===== include/tcc_pkg.sv
// Types shared by the timer and capture block
package tcc_pkg;

   // Capture trigger modes
   typedef enum logic [1:0]
   {
      TCC_CAP_FALL   = 2'b00,
      TCC_CAP_RISE   = 2'b01,
      TCC_CAP_RISE4  = 2'b10,
      TCC_CAP_RISE16 = 2'b11
   } tcc_cap_mode_e;

   typedef logic [15:0] tcc_word_t;
   typedef logic [7:0]  tcc_byte_t;

endpackage

// ===== include/tcc_regs.svh
// Register offsets, field positions, reset values and timing constants for the timer block
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// ==========================================================
// Register map
`define TCC_ADDR_W          8
`define TCC_CFG_OFFSET      8'h16
`define TCC_FIRST_OFFSET    8'h18
`define TCC_SECOND_OFFSET   8'h19
`define TCC_WIDE_LO_OFFSET  8'h1a
`define TCC_WIDE_HI_OFFSET  8'h1b
`define TCC_CAP1_LO_OFFSET  8'h1c
`define TCC_CAP1_HI_OFFSET  8'h1d
`define TCC_CAP2_LO_OFFSET  8'h1e
`define TCC_CAP2_HI_OFFSET  8'h1f
`define TCC_CFG_RESET       8'h00
`define TCC_READ_UNMAPPED   8'h00

// ==========================================================
// Configuration fields
`define TCC_CAP2_MODE_HI    7
`define TCC_CAP2_MODE_LO    6
`define TCC_CAP1_MODE_HI    5
`define TCC_CAP1_MODE_LO    4
`define TCC_CASCADE_BIT     3
`define TCC_WIDE_SRC_BIT    2
`define TCC_SECOND_SRC_BIT  1
`define TCC_FIRST_SRC_BIT   0

// ==========================================================
// Counts
`define TCC_CLK_MHZ         250
`define TCC_INSN_DIV        4
`define TCC_INSN_DIV_LAST   2'h3
`define TCC_DIV4_LAST       4'h3
`define TCC_DIV16_LAST      4'hf

`endif

// ===== logic/tcc_capture_channel.sv
// One capture channel: synchronised input, mode-selected trigger, 16-bit latch
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"

module tcc_capture_channel
   import tcc_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 cap_pin_i,
   input  wire tcc_pkg::tcc_cap_mode_e mode_i,
   input  wire tcc_pkg::tcc_word_t   time_base_i,
   output logic                      capture_o,
   output tcc_pkg::tcc_word_t        value_o
);

   // ==========================================================
   // Input synchroniser and edge detection
   logic       meta_reg;
   logic       sync_reg;
   logic       last_reg;
   logic [3:0] pre_reg;
   logic [3:0] pre_next;
   logic       rise;
   logic       fall;
   logic       pre_last;
   logic       trigger;

   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;

   // Prescaler end depends on the mode
   assign pre_last = (mode_i == TCC_CAP_RISE4) ? (pre_reg == `TCC_DIV4_LAST)
                                               : (pre_reg == `TCC_DIV16_LAST);
   assign pre_next = pre_last ? 4'h0 : pre_reg + 4'h1;

   // Trigger selection per mode
   always_comb
   begin
      unique case (mode_i)
         TCC_CAP_FALL:   trigger = fall;
         TCC_CAP_RISE:   trigger = rise;
         TCC_CAP_RISE4:  trigger = rise & pre_last;
         TCC_CAP_RISE16: trigger = rise & pre_last;
      endcase
   end

   // Two-stage synchroniser; first stage is read only by the second.
   // It keeps sampling through reset, so every stage holds the pin level
   // when reset ends and no false edge reaches the prescaler or trigger.
   always_ff @(posedge clk_i)
   begin
      meta_reg <= cap_pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
   end

   // Rising-edge prescaler
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         pre_reg <= 4'h0;
      else if (rise)
         pre_reg <= pre_next;
   end

   // Latch the common time base on a qualifying trigger
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         value_o   <= 16'h0000;
         capture_o <= 1'b0;
      end
      else
      begin
         capture_o <= trigger;
         if (trigger)
            value_o <= time_base_i;
      end
   end

endmodule
`default_nettype wire

// ===== logic/tcc_timer_capture.sv
// Timer and capture control: configuration register, three timers, two capture channels
//
// What this block does
// - Capture two mode bits 7-6 pick falling, rising, fourth or sixteenth rising edge.
// - Capture one mode bits 5-4 use the same four trigger choices.
// - Cascade bit set joins second and first byte timers into one 16-bit timer.
// - Wide timer source bit set counts falling edges of its own external pin.
// - Second timer source bit set counts falling edges of the shared pin.
// - First timer source bit set counts falling edges of the shared pin.
// - Every capture latches the current 16-bit wide timer value.
// - Internal count source is the clock divided by four.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"

module tcc_timer_capture
   import tcc_pkg::*;
(
   input  wire logic                     clk_i,
   input  wire logic                     reset_i,
   input  wire logic [`TCC_ADDR_W-1:0]   addr_i,
   input  wire logic [7:0]               wdata_i,
   input  wire logic                     wr_i,
   input  wire logic                     rd_i,
   output logic [7:0]                    rdata_o,
   input  wire logic                     shared_ext_count_pin_i,
   input  wire logic                     wide_timer_ext_pin_i,
   input  wire logic                     cap_one_pin_i,
   input  wire logic                     cap_two_pin_i,
   output logic                          cap_one_event_o,
   output logic                          cap_two_event_o
);

   // ==========================================================
   // Register state
   tcc_byte_t     timer_capture_config_reg;
   tcc_byte_t     first_byte_timer_reg;
   tcc_byte_t     second_byte_timer_reg;
   tcc_word_t     wide_capture_timer_reg;
   logic [1:0]    div_reg;
   logic          shared_meta_reg;
   logic          shared_sync_reg;
   logic          shared_last_reg;
   logic          wide_meta_reg;
   logic          wide_sync_reg;
   logic          wide_last_reg;
   tcc_word_t     cap_one_value;
   tcc_word_t     cap_two_value;
   tcc_byte_t     rdata_next;

   // ==========================================================
   // Configuration fields
   tcc_cap_mode_e cap_two_trigger_mode;
   tcc_cap_mode_e cap_one_trigger_mode;
   logic          timer_cascade_select;
   logic          wide_timer_source_select;
   logic          second_timer_source_select;
   logic          first_timer_source_select;

   assign cap_two_trigger_mode = tcc_cap_mode_e'(
      timer_capture_config_reg[`TCC_CAP2_MODE_HI:`TCC_CAP2_MODE_LO]);
   assign cap_one_trigger_mode = tcc_cap_mode_e'(
      timer_capture_config_reg[`TCC_CAP1_MODE_HI:`TCC_CAP1_MODE_LO]);
   assign timer_cascade_select       = timer_capture_config_reg[`TCC_CASCADE_BIT];
   assign wide_timer_source_select   = timer_capture_config_reg[`TCC_WIDE_SRC_BIT];
   assign second_timer_source_select = timer_capture_config_reg[`TCC_SECOND_SRC_BIT];
   assign first_timer_source_select  = timer_capture_config_reg[`TCC_FIRST_SRC_BIT];

   // ==========================================================
   // Address decode
   logic wr_cfg;
   logic wr_first;
   logic wr_second;
   logic wr_wide_lo;
   logic wr_wide_hi;

   assign wr_cfg     = wr_i & (addr_i == `TCC_CFG_OFFSET);
   assign wr_first   = wr_i & (addr_i == `TCC_FIRST_OFFSET);
   assign wr_second  = wr_i & (addr_i == `TCC_SECOND_OFFSET);
   assign wr_wide_lo = wr_i & (addr_i == `TCC_WIDE_LO_OFFSET);
   assign wr_wide_hi = wr_i & (addr_i == `TCC_WIDE_HI_OFFSET);

   // ==========================================================
   // Count sources
   logic insn_tick;
   logic shared_fall;
   logic wide_fall;
   logic first_tick;
   logic second_tick;
   logic wide_tick;
   logic first_wrap;
   logic second_inc;

   // One internal tick every fourth clock
   assign insn_tick   = (div_reg == `TCC_INSN_DIV_LAST);
   assign shared_fall = ~shared_sync_reg & shared_last_reg;
   assign wide_fall   = ~wide_sync_reg & wide_last_reg;

   assign first_tick  = first_timer_source_select ? shared_fall : insn_tick;
   assign wide_tick   = wide_timer_source_select ? wide_fall : insn_tick;
   assign first_wrap  = first_tick & (first_byte_timer_reg == 8'hff);
   // In cascade the second timer steps on the first one's wrap
   assign second_tick = second_timer_source_select ? shared_fall : insn_tick;
   assign second_inc  = timer_cascade_select ? first_wrap : second_tick;

   // Divider for the internal count source
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         div_reg <= 2'h0;
      else
         div_reg <= div_reg + 2'h1;
   end

   // Pin synchronisers; first stages feed only the second
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         shared_meta_reg <= 1'b0;
         shared_sync_reg <= 1'b0;
         shared_last_reg <= 1'b0;
         wide_meta_reg   <= 1'b0;
         wide_sync_reg   <= 1'b0;
         wide_last_reg   <= 1'b0;
      end
      else
      begin
         shared_meta_reg <= shared_ext_count_pin_i;
         shared_sync_reg <= shared_meta_reg;
         shared_last_reg <= shared_sync_reg;
         wide_meta_reg   <= wide_timer_ext_pin_i;
         wide_sync_reg   <= wide_meta_reg;
         wide_last_reg   <= wide_sync_reg;
      end
   end

   // Configuration register
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         timer_capture_config_reg <= `TCC_CFG_RESET;
      else if (wr_cfg)
         timer_capture_config_reg <= wdata_i;
   end

   // Byte timers; a write holds off that timer's increment that cycle
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         first_byte_timer_reg  <= 8'h00;
         second_byte_timer_reg <= 8'h00;
      end
      else
      begin
         if (wr_first)
            first_byte_timer_reg <= wdata_i;
         else if (first_tick)
            first_byte_timer_reg <= first_byte_timer_reg + 8'h01;
         if (wr_second)
            second_byte_timer_reg <= wdata_i;
         else if (second_inc)
            second_byte_timer_reg <= second_byte_timer_reg + 8'h01;
      end
   end

   // Wide timer, the common capture time base
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         wide_capture_timer_reg <= 16'h0000;
      else if (wr_wide_lo)
         wide_capture_timer_reg[7:0] <= wdata_i;
      else if (wr_wide_hi)
         wide_capture_timer_reg[15:8] <= wdata_i;
      else if (wide_tick)
         wide_capture_timer_reg <= wide_capture_timer_reg + 16'h0001;
   end

   // ==========================================================
   // Capture channels
   tcc_capture_channel u_cap_one
   (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .cap_pin_i   (cap_one_pin_i),
      .mode_i      (cap_one_trigger_mode),
      .time_base_i (wide_capture_timer_reg),
      .capture_o   (cap_one_event_o),
      .value_o     (cap_one_value)
   );

   tcc_capture_channel u_cap_two
   (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .cap_pin_i   (cap_two_pin_i),
      .mode_i      (cap_two_trigger_mode),
      .time_base_i (wide_capture_timer_reg),
      .capture_o   (cap_two_event_o),
      .value_o     (cap_two_value)
   );

   // ==========================================================
   // Read mux
   always_comb
   begin
      unique case (addr_i)
         `TCC_CFG_OFFSET:     rdata_next = timer_capture_config_reg;
         `TCC_FIRST_OFFSET:   rdata_next = first_byte_timer_reg;
         `TCC_SECOND_OFFSET:  rdata_next = second_byte_timer_reg;
         `TCC_WIDE_LO_OFFSET: rdata_next = wide_capture_timer_reg[7:0];
         `TCC_WIDE_HI_OFFSET: rdata_next = wide_capture_timer_reg[15:8];
         `TCC_CAP1_LO_OFFSET: rdata_next = cap_one_value[7:0];
         `TCC_CAP1_HI_OFFSET: rdata_next = cap_one_value[15:8];
         `TCC_CAP2_LO_OFFSET: rdata_next = cap_two_value[7:0];
         `TCC_CAP2_HI_OFFSET: rdata_next = cap_two_value[15:8];
         default:             rdata_next = `TCC_READ_UNMAPPED;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         rdata_o <= 8'h00;
      else if (rd_i)
         rdata_o <= rdata_next;
      else
         rdata_o <= 8'h00;
   end

endmodule
`default_nettype wire

// ===== sim/tb_timer_capture_control.sv
// Self-checking bench for the timer and capture block
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"

module tb_timer_capture_control;
   import tcc_pkg::*;
   // ==========================================================
   // Signals, partner and design
   logic       clk_i   = 1'b0;
   logic       reset_i = 1'b1;
   logic       wr_i    = 1'b0;
   logic       rd_i    = 1'b0;
   logic [7:0] addr_i  = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] rdata_o, v0, v1;
   logic       ev1, ev2;
   logic [3:0] pins;
   logic [7:0] tmr [3] = '{8'h18, 8'h19, 8'h1a};
   int         order [4] = '{2, 3, 0, 1};
   int         npul [4] = '{2, 2, 16, 32};
   int         err_total = 0, compares = 0, seed = 35, cyc = 0, n1 = 0, n2 = 0;

   always #2 clk_i = ~clk_i;
   tcc_pin_model pm (.clk_i(clk_i), .pins_o(pins));
   tcc_timer_capture dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .shared_ext_count_pin_i(pins[0]), .wide_timer_ext_pin_i(pins[1]),
      .cap_one_pin_i(pins[2]), .cap_two_pin_i(pins[3]),
      .cap_one_event_o(ev1), .cap_two_event_o(ev2));

   // Event counters and the hang limit
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (ev1 === 1'b1) n1 <= n1 + 1;
      if (ev2 === 1'b1) n2 <= n2 + 1;
      if (cyc == 20000)
      begin
         err_total++;
         $display("unexpected at %0t: run timed out", $time);
         conclude();
      end
   end

   // ==========================================================
   // Bus tasks, compare and expectations
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Random level hold, slow or prompt
   function automatic int hold();
      return 3 + {$random(seed)} % 4;
   endfunction
   // Captures expected from n pulses in trigger mode m
   function automatic logic [7:0] expn(input int m, input int n);
      return 8'(m < 2 ? n : (m == 2 ? n / 4 : n / 16));
   endfunction

   // ==========================================================
   // Main sequence
   initial
   begin
      logic [15:0] w;
      int          m, n, b;
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(`TCC_CFG_OFFSET, v0);
      chk(v0, `TCC_CFG_RESET);
      wr(8'h17, 8'hff);
      rd(8'h17, v0);
      chk(v0, 8'h00);
      rd(`TCC_CFG_OFFSET, v0);
      chk(v0, `TCC_CFG_RESET);
      repeat (6)
      begin
         w = 16'($random(seed));
         wr(`TCC_CFG_OFFSET, w[7:0]);
         rd(`TCC_CFG_OFFSET, v0);
         chk(v0, w[7:0]);
         rd(`TCC_CFG_OFFSET, v0);
         chk(v0, w[7:0]);
      end
      $display("test config done");
      wr(`TCC_CFG_OFFSET, 8'h00);
      foreach (tmr[i])
      begin
         wr(tmr[i], 8'h00);
         rd(tmr[i], v0);
         repeat (38) @(posedge clk_i);
         rd(tmr[i], v1);
         chk(v1 - v0, 8'h0a);
      end
      $display("test internal count done");
      wr(`TCC_CFG_OFFSET, 8'h07);
      foreach (tmr[i]) wr(tmr[i], 8'h00);
      n = 1 + {$random(seed)} % 8;
      repeat (n) pm.pulse(0, hold());
      repeat (n + 2) pm.pulse(1, hold());
      repeat (6) @(posedge clk_i);
      foreach (tmr[i])
      begin
         rd(tmr[i], v0);
         chk(v0, 8'(i == 2 ? n + 2 : n));
      end
      wr(`TCC_CFG_OFFSET, 8'h09);
      wr(8'h18, 8'hfe);
      wr(8'h19, 8'h05);
      repeat (3) pm.pulse(0, hold());
      repeat (6) @(posedge clk_i);
      rd(8'h18, v0);
      chk(v0, 8'h01);
      rd(8'h19, v0);
      chk(v0, 8'h06);
      $display("test external count done");
      for (int c = 0; c < 2; c++)
         foreach (order[k])
         begin
            m = order[k];
            w = 16'($random(seed));
            wr(`TCC_CFG_OFFSET, 8'(m << (c ? 6 : 4)) | 8'h04);
            wr(8'h1a, w[7:0]);
            wr(8'h1b, w[15:8]);
            b = c ? n2 : n1;
            repeat (npul[m]) pm.pulse(2 + c, hold());
            repeat (6) @(posedge clk_i);
            chk(8'((c ? n2 : n1) - b), expn(m, npul[m]));
            rd(8'h1c + 8'(2 * c), v0);
            chk(v0, w[7:0]);
            rd(8'h1d + 8'(2 * c), v0);
            chk(v0, w[15:8]);
         end
      $display("test capture done");
      conclude();
   end
endmodule

`default_nettype wire

// ===== sim/tcc_pin_model.sv
// Far-side model: external count pins and capture inputs
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_model
(
   input  wire logic       clk_i,
   output logic [3:0]      pins_o
);
   // Pins rest high, as on a pulled-up port, so each pulse is a fall then a rise
   initial pins_o = 4'hf;

   // One low pulse on pin p, each level held h cycles; callers keep h at 3 or more
   task automatic pulse(input int p, input int h);
      @(posedge clk_i);
      pins_o[p] <= 1'b0;
      repeat (h) @(posedge clk_i);
      pins_o[p] <= 1'b1;
      repeat (h) @(posedge clk_i);
   endtask
endmodule

`default_nettype wire

// ===== sim/tcc_timer_capture_asserts.sv
// Port-level checks for the timer and capture block
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.svh"

module tcc_timer_capture_asserts
(
   input  wire logic                   clk_i,
   input  wire logic                   reset_i,
   input  wire logic [`TCC_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   input  wire logic [7:0]             rdata_o,
   input  wire logic                   shared_ext_count_pin_i,
   input  wire logic                   wide_timer_ext_pin_i,
   input  wire logic                   cap_one_pin_i,
   input  wire logic                   cap_two_pin_i,
   input  wire logic                   cap_one_event_o,
   input  wire logic                   cap_two_event_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // ==========================================================
   // Address decode and bus steps
   wire logic mapped;
   assign mapped = addr_i == `TCC_CFG_OFFSET ||
                   (addr_i >= `TCC_FIRST_OFFSET && addr_i <= `TCC_CAP2_HI_OFFSET);
   sequence cfg_wr_s; wr_i && !rd_i && addr_i == `TCC_CFG_OFFSET; endsequence
   sequence cfg_rd_s; rd_i && !wr_i && addr_i == `TCC_CFG_OFFSET; endsequence
   // Write, one idle write slot, then a read of the same register
   property cfg_back_p;
      cfg_wr_s ##1 !wr_i ##1 cfg_rd_s |=> rdata_o == $past(wdata_i, 3);
   endproperty
   // Two reads with no write between them return the same value
   property cfg_hold_p;
      cfg_rd_s ##1 !wr_i ##1 cfg_rd_s |=> rdata_o == $past(rdata_o, 2);
   endproperty

   // ==========================================================
   // Assertions
   rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   cfg_back_a: assert property (cfg_back_p)
      else $error("config readback differs from write");
   cfg_hold_a: assert property (cfg_hold_p)
      else $error("config changed without a write");
   one_pulse_a: assert property (cap_one_event_o |=> !cap_one_event_o)
      else $error("capture one event longer than a cycle");
   two_pulse_a: assert property (cap_two_event_o |=> !cap_two_event_o)
      else $error("capture two event longer than a cycle");
   one_cause_a: assert property (cap_one_event_o |->
      $past(cap_one_pin_i, 2) != $past(cap_one_pin_i, 5))
      else $error("capture one event without pin edge");
   two_cause_a: assert property (cap_two_event_o |->
      $past(cap_two_pin_i, 2) != $past(cap_two_pin_i, 5))
      else $error("capture two event without pin edge");
endmodule

bind tcc_timer_capture tcc_timer_capture_asserts u_chk
(
   .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .shared_ext_count_pin_i(shared_ext_count_pin_i),
   .wide_timer_ext_pin_i(wide_timer_ext_pin_i), .cap_one_pin_i(cap_one_pin_i),
   .cap_two_pin_i(cap_two_pin_i), .cap_one_event_o(cap_one_event_o),
   .cap_two_event_o(cap_two_event_o)
);

`default_nettype wire
